// ---- src/saved_bank_pkg.sv ----
// constants, types and register map of the saved calibration results bank
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package saved_bank_pkg;

    // ------------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------------
    localparam logic [15:0] UV_SAVED_FILTER_COUNT_REG = 16'h9D1C;
    localparam logic [15:0] IR_GAIN_TARGET_400_REG    = 16'h9D26;
    localparam logic [15:0] IR_GAIN_TARGET_600_REG    = 16'h9D30;
    localparam logic [15:0] IR_GAIN_TARGET_1200_REG   = 16'h9D3A;
    localparam logic [15:0] UV_GAIN_TARGET_400_REG    = 16'h9D44;
    localparam logic [15:0] UV_GAIN_TARGET_600_REG    = 16'h9D4E;
    localparam logic [15:0] UV_GAIN_TARGET_1200_REG   = 16'h9D58;
    localparam logic [15:0] TUBE_SAVED_COUNT_REG      = 16'h9D62;
    localparam logic [15:0] IR_AUTO_GAIN_RESULT_REG   = 16'h9D63;
    localparam logic [15:0] TUBE_AUTO_GAIN_RESULT_REG = 16'h9D64;
    localparam logic [15:0] SOLID_UV_AUTO_GAIN_RESULT_REG = 16'h9D65;
    localparam logic [15:0] AUTO_GAIN_FILE_INDEX_REG  = 16'h9D66;

    // ------------------------------------------------------------------
    // geometry and field layout
    // ------------------------------------------------------------------
    localparam int          FILTER_COUNT   = 10;
    localparam logic [3:0]  FILTER_LAST    = 4'h9;
    localparam logic [15:0] GROUP_SPAN     = 16'h000A;
    localparam int          GROUP_COUNT    = 7;
    localparam logic [7:0]  GAIN_MAX       = 8'h63;
    localparam logic [7:0]  FILE_NEVER_RUN = 8'hFF;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [7:0]  GAIN_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // exception codes
    // ------------------------------------------------------------------
    localparam logic [7:0] EXC_NONE         = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] uv_1200;
        logic [7:0] uv_600;
        logic [7:0] uv_400;
        logic [7:0] ir_1200;
        logic [7:0] ir_600;
        logic [7:0] ir_400;
        logic signed [15:0] uv_count;
    } filter_result_t;

    typedef struct packed {
        logic               valid;
        logic [3:0]         filter_sel;
        filter_result_t     result;
        logic               tube_valid;
        logic signed [15:0] tube_count;
    } filter_capture_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] ir_gain;
        logic [7:0] tube_gain;
        logic [7:0] solid_uv_gain;
        logic [2:0] active_file;
    } gain_capture_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [7:0]  exception;
    } host_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOOKUP
    } bank_state_t;

endpackage : saved_bank_pkg

// ---- src/filter_result_mem.sv ----
// ten-entry memory of per-filter calibration results with registered read
`timescale 1ns/1ps
`default_nettype none
module filter_result_mem (
    input  wire logic                           clk,
    input  wire logic                           arst_n,
    input  wire logic                           wr_en,
    input  wire logic [3:0]                     wr_addr,
    input  wire saved_bank_pkg::filter_result_t wr_data,
    input  wire logic [3:0]                     rd_addr,
    output      saved_bank_pkg::filter_result_t rd_data
);
    import saved_bank_pkg::*;

    typedef struct packed {
        filter_result_t [FILTER_COUNT-1:0] word;
        filter_result_t                    rdata;
    } mem_state_t;

    mem_state_t st_reg;
    mem_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // read-first: a capture in the same cycle shows on the next read
        if (rd_addr <= FILTER_LAST) begin
            st_next.rdata = st_reg.word[rd_addr];
        end else begin
            st_next.rdata = '0;
        end
        if (wr_en && (wr_addr <= FILTER_LAST)) begin
            st_next.word[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rdata;

endmodule : filter_result_mem
`default_nettype wire

// ---- src/auto_gain_saved_results_bank.sv ----
// read-only bank of auto-filter and auto-gain calibration results
`timescale 1ns/1ps
`default_nettype none
module auto_gain_saved_results_bank (
    input  wire logic                            clk,
    input  wire logic                            arst_n,
    input  wire saved_bank_pkg::filter_capture_t filter_cap,
    input  wire saved_bank_pkg::gain_capture_t   gain_cap,
    input  wire saved_bank_pkg::host_req_t       host_req,
    output      logic                            req_ready,
    output      saved_bank_pkg::host_rsp_t       host_rsp
);
    import saved_bank_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // gains above range are pinned so the bank never holds more than 99
    function automatic logic [7:0] clamp_gain(input logic [7:0] g);
        clamp_gain = (g > GAIN_MAX) ? GAIN_MAX : g;
    endfunction : clamp_gain

    // group 0..6 inside the per-filter window, 7 when outside
    function automatic logic [2:0] group_of(input logic [15:0] a);
        logic [15:0] off;
        off = a - UV_SAVED_FILTER_COUNT_REG;
        group_of = 3'h7;
        if (a >= UV_SAVED_FILTER_COUNT_REG && a < TUBE_SAVED_COUNT_REG) begin
            group_of = 3'(off / GROUP_SPAN);
        end
    endfunction : group_of

    function automatic logic [3:0] filter_of(input logic [15:0] a);
        logic [15:0] off;
        off = a - UV_SAVED_FILTER_COUNT_REG;
        filter_of = 4'(off % GROUP_SPAN);
    endfunction : filter_of

    function automatic logic in_bank(input logic [15:0] a);
        in_bank = (a >= UV_SAVED_FILTER_COUNT_REG) && (a <= AUTO_GAIN_FILE_INDEX_REG);
    endfunction : in_bank

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        bank_state_t        fsm;
        logic               ready;
        logic               pend_write;
        logic [15:0]        pend_addr;
        logic signed [15:0] tube_count;
        logic [7:0]         ir_gain;
        logic [7:0]         tube_gain;
        logic [7:0]         solid_uv_gain;
        logic [7:0]         file_index;
        host_rsp_t          rsp;
    } bank_st_t;

    localparam bank_st_t ST_RESET = '{
        fsm:           ST_IDLE,
        ready:         1'b1,
        pend_write:    1'b0,
        pend_addr:     16'h0000,
        tube_count:    COUNT_RESET,
        ir_gain:       GAIN_RESET,
        tube_gain:     GAIN_RESET,
        solid_uv_gain: GAIN_RESET,
        file_index:    FILE_NEVER_RUN,
        rsp:           '0
    };

    bank_st_t       st_reg;
    bank_st_t       st_next;
    filter_result_t cap_word;
    filter_result_t rd_word;
    logic           take;

    assign take = host_req.valid && st_reg.ready;

    // ------------------------------------------------------------------
    // per-filter capture
    // ------------------------------------------------------------------
    always_comb begin
        cap_word          = filter_cap.result;
        cap_word.ir_400   = clamp_gain(filter_cap.result.ir_400);
        cap_word.uv_400   = clamp_gain(filter_cap.result.uv_400);
        cap_word.ir_600   = clamp_gain(filter_cap.result.ir_600);
        cap_word.uv_600   = clamp_gain(filter_cap.result.uv_600);
        cap_word.ir_1200  = clamp_gain(filter_cap.result.ir_1200);
        cap_word.uv_1200  = clamp_gain(filter_cap.result.uv_1200);
    end

    filter_result_mem u_mem (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (filter_cap.valid),
        .wr_addr (filter_cap.filter_sel),
        .wr_data (cap_word),
        .rd_addr (filter_of(host_req.addr)),
        .rd_data (rd_word)
    );

    // ------------------------------------------------------------------
    // captures and host access
    // ------------------------------------------------------------------
    always_comb begin
        st_next           = st_reg;
        st_next.rsp.valid = 1'b0;

        if (filter_cap.tube_valid) begin
            st_next.tube_count = filter_cap.tube_count;
        end
        if (gain_cap.valid) begin
            st_next.ir_gain       = clamp_gain(gain_cap.ir_gain);
            st_next.tube_gain     = clamp_gain(gain_cap.tube_gain);
            st_next.solid_uv_gain = clamp_gain(gain_cap.solid_uv_gain);
            st_next.file_index    = {5'h00, gain_cap.active_file};
        end

        case (st_reg.fsm)
            ST_IDLE: begin
                if (take) begin
                    st_next.fsm        = ST_LOOKUP;
                    st_next.ready      = 1'b0;
                    st_next.pend_write = host_req.write;
                    st_next.pend_addr  = host_req.addr;
                end
            end
            ST_LOOKUP: begin
                st_next.fsm           = ST_IDLE;
                st_next.ready         = 1'b1;
                st_next.rsp.valid     = 1'b1;
                st_next.rsp.data      = 16'h0000;
                st_next.rsp.exception = EXC_NONE;
                if (!in_bank(st_reg.pend_addr)) begin
                    st_next.rsp.exception = EXC_ILLEGAL_ADDR;
                end else if (st_reg.pend_write) begin
                    // nothing is stored; the host sees the refusal
                    st_next.rsp.exception = EXC_ILLEGAL_FUNC;
                end else begin
                    case (group_of(st_reg.pend_addr))
                        3'h0: st_next.rsp.data = rd_word.uv_count;
                        3'h1: st_next.rsp.data = {8'h00, rd_word.ir_400};
                        3'h2: st_next.rsp.data = {8'h00, rd_word.ir_600};
                        3'h3: st_next.rsp.data = {8'h00, rd_word.ir_1200};
                        3'h4: st_next.rsp.data = {8'h00, rd_word.uv_400};
                        3'h5: st_next.rsp.data = {8'h00, rd_word.uv_600};
                        3'h6: st_next.rsp.data = {8'h00, rd_word.uv_1200};
                        default: begin
                            case (st_reg.pend_addr)
                                TUBE_SAVED_COUNT_REG:
                                    st_next.rsp.data = st_reg.tube_count;
                                IR_AUTO_GAIN_RESULT_REG:
                                    st_next.rsp.data = {8'h00, st_reg.ir_gain};
                                TUBE_AUTO_GAIN_RESULT_REG:
                                    st_next.rsp.data = {8'h00, st_reg.tube_gain};
                                SOLID_UV_AUTO_GAIN_RESULT_REG:
                                    st_next.rsp.data = {8'h00, st_reg.solid_uv_gain};
                                AUTO_GAIN_FILE_INDEX_REG:
                                    st_next.rsp.data = {8'h00, st_reg.file_index};
                                default:
                                    st_next.rsp.exception = EXC_ILLEGAL_ADDR;
                            endcase
                        end
                    endcase
                end
            end
            default: begin
                st_next = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign req_ready = st_reg.ready;
    assign host_rsp  = st_reg.rsp;

endmodule : auto_gain_saved_results_bank
`default_nettype wire

// ---- verif/saved_bank_props.sv ----
// assertions on the ports of the saved results bank
`timescale 1ns/1ps
`default_nettype none
module saved_bank_props (
    input wire logic                            clk,
    input wire logic                            arst_n,
    input wire saved_bank_pkg::filter_capture_t filter_cap,
    input wire saved_bank_pkg::gain_capture_t   gain_cap,
    input wire saved_bank_pkg::host_req_t       host_req,
    input wire logic                            req_ready,
    input wire saved_bank_pkg::host_rsp_t       host_rsp
);
    import saved_bank_pkg::*;
    logic taken;
    logic rd;
    logic in_map;
    logic is_gain;
    assign taken = host_req.valid && req_ready;
    assign rd = taken && !host_req.write;
    assign in_map = host_req.addr >= UV_SAVED_FILTER_COUNT_REG
                 && host_req.addr <= AUTO_GAIN_FILE_INDEX_REG;
    assign is_gain = (host_req.addr >= IR_GAIN_TARGET_400_REG
                      && host_req.addr < TUBE_SAVED_COUNT_REG)
                  || (host_req.addr > TUBE_SAVED_COUNT_REG
                      && host_req.addr < AUTO_GAIN_FILE_INDEX_REG);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------------------
    // host port
    // ----------------------------------------------------------------------
    property p_latency;
        taken |-> ##1 (!req_ready && !host_rsp.valid) ##1 (host_rsp.valid && req_ready);
    endproperty
    a_latency: assert property (p_latency) else $error("response latency wrong");
    property p_no_orphan;
        host_rsp.valid |-> $past(taken, 2);
    endproperty
    a_no_orphan: assert property (p_no_orphan) else $error("response without request");
    property p_read_ok;
        rd && in_map |-> ##2 host_rsp.exception == EXC_NONE;
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("mapped read refused");
    property p_write_refused;
        taken && host_req.write && in_map |-> ##2 host_rsp.exception == EXC_ILLEGAL_FUNC;
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("write not refused");
    property p_unmapped;
        taken && !in_map
            |-> ##2 (host_rsp.exception == EXC_ILLEGAL_ADDR && host_rsp.data == 16'h0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_gain_range;
        rd && is_gain |-> ##2 host_rsp.data <= {8'h00, GAIN_MAX};
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain above range");
    property p_file_range;
        rd && host_req.addr == AUTO_GAIN_FILE_INDEX_REG
            |-> ##2 (host_rsp.data == {8'h00, FILE_NEVER_RUN} || host_rsp.data <= 16'h0007);
    endproperty
    a_file_range: assert property (p_file_range) else $error("file index out of range");
    property p_file_capture;
        gain_cap.valid ##1 (rd && host_req.addr == AUTO_GAIN_FILE_INDEX_REG && !gain_cap.valid)
            ##1 !gain_cap.valid
            |-> ##1 host_rsp.data == {13'h0000, $past(gain_cap.active_file, 3)};
    endproperty
    a_file_capture: assert property (p_file_capture) else $error("file index not captured");
endmodule : saved_bank_props
bind auto_gain_saved_results_bank saved_bank_props i_saved_bank_props (
    .clk(clk), .arst_n(arst_n), .filter_cap(filter_cap), .gain_cap(gain_cap),
    .host_req(host_req), .req_ready(req_ready), .host_rsp(host_rsp));
`default_nettype wire

// ---- verif/host_model.sv ----
// host model issuing register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                      clk,
    output var  saved_bank_pkg::host_req_t host_req,
    input  wire logic                      req_ready,
    input  wire saved_bank_pkg::host_rsp_t host_rsp
);
    import saved_bank_pkg::*;
    initial host_req = '0;
    // one request outstanding; entered and left on a falling edge
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                        output logic [15:0] d, output logic [7:0] e);
        int n;
        n = 0;
        host_req = '{valid: 1'b1, write: wr, addr: a, wdata: wd};
        while (req_ready !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        // released lines flip so that a stale value cannot pass as held
        host_req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
        n = 0;
        while (host_rsp.valid !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        d = host_rsp.data;
        e = (n < 8) ? host_rsp.exception : 8'hEE;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking testbench of the saved results bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import saved_bank_pkg::*;
    logic            clk;
    logic            arst_n;
    filter_capture_t filter_cap;
    gain_capture_t   gain_cap;
    host_req_t       host_req;
    logic            req_ready;
    host_rsp_t       host_rsp;
    logic [15:0]     exp_val [0:74];
    int              miscompares;
    int              checks_done;
    logic [15:0]     wr_addr [0:2];
    always #12.5 clk = ~clk;
    auto_gain_saved_results_bank i_auto_gain_saved_results_bank (.clk(clk), .arst_n(arst_n),
        .filter_cap(filter_cap), .gain_cap(gain_cap), .host_req(host_req),
        .req_ready(req_ready), .host_rsp(host_rsp));
    host_model i_host_model (.clk(clk), .host_req(host_req), .req_ready(req_ready),
        .host_rsp(host_rsp));
    // ----------------------------------------------------------------------
    // checking and access tasks
    // ----------------------------------------------------------------------
    task automatic print_verdict;
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] expv);
        checks_done++;
        if (seen !== expv) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, expv, seen);
        end
    endtask : chk
    function automatic logic [15:0] clamp(input logic [7:0] g);
        return {8'h00, (g > GAIN_MAX) ? GAIN_MAX : g};
    endfunction : clamp
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] xd,
                          input logic [7:0] xe);
        logic [15:0] d;
        logic [7:0]  e;
        i_host_model.xfer(wr, a, 16'h5A5A, d, e);
        chk("exception", {8'h00, e}, {8'h00, xe});
        if (!wr) chk("read data", d, xd);
        chk("ready after response", {15'h0000, req_ready}, 16'h0001);
    endtask : access
    task automatic check_all;
        for (int i = 0; i < 75; i++) begin
            access(1'b0, UV_SAVED_FILTER_COUNT_REG + 16'(i), exp_val[i], EXC_NONE);
        end
    endtask : check_all
    task automatic reset_exp;
        foreach (exp_val[i]) exp_val[i] = 16'h0000;
        exp_val[74] = {8'h00, FILE_NEVER_RUN};
    endtask : reset_exp
    // leaves valid high so back-to-back captures never toggle it in one step
    task automatic cap_filter(input int s, input filter_result_t r);
        filter_cap.valid = 1'b1;
        filter_cap.filter_sel = 4'(s);
        filter_cap.result = r;
        @(negedge clk);
        if (s < FILTER_COUNT) begin
            exp_val[s] = r.uv_count;
            exp_val[10 + s] = clamp(r.ir_400);
            exp_val[20 + s] = clamp(r.ir_600);
            exp_val[30 + s] = clamp(r.ir_1200);
            exp_val[40 + s] = clamp(r.uv_400);
            exp_val[50 + s] = clamp(r.uv_600);
            exp_val[60 + s] = clamp(r.uv_1200);
        end
    endtask : cap_filter
    task automatic cap_gain(input logic [7:0] ir, input logic [7:0] tu, input logic [7:0] su,
                            input logic [2:0] f);
        gain_cap = '{valid: 1'b1, ir_gain: ir, tube_gain: tu, solid_uv_gain: su, active_file: f};
        @(negedge clk);
        gain_cap.valid = 1'b0;
        exp_val[71] = clamp(ir);
        exp_val[72] = clamp(tu);
        exp_val[73] = clamp(su);
        exp_val[74] = {13'h0000, f};
    endtask : cap_gain
    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        filter_cap = '0;
        gain_cap = '0;
        miscompares = 0;
        checks_done = 0;
        wr_addr = '{UV_SAVED_FILTER_COUNT_REG, TUBE_SAVED_COUNT_REG, AUTO_GAIN_FILE_INDEX_REG};
        reset_exp();
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        check_all();
        for (int f = 0; f < 10; f++) begin
            cap_filter(f, '{uv_1200: 8'h63 - 8'(f), uv_600: 8'h30 + 8'(f),
                uv_400: 8'h20 + 8'(f), ir_1200: (f == 4) ? 8'hFF : 8'h10 + 8'(f),
                ir_600: 8'h63 - 8'(11 * f), ir_400: 8'(11 * f),
                uv_count: (f == 9) ? 16'h7FFF : 16'h8000 + 16'(f * 4660)});
        end
        for (int s = 10; s < 16; s++) begin
            cap_filter(s, filter_result_t'(64'hA5A5_A5A5_A5A5_A5A5));
        end
        filter_cap.valid = 1'b0;
        filter_cap.tube_valid = 1'b1;
        filter_cap.tube_count = 16'hCFC7;
        @(negedge clk);
        filter_cap.tube_valid = 1'b0;
        exp_val[70] = 16'hCFC7;
        cap_gain(8'h00, 8'h63, 8'hC8, 3'h5);
        check_all();
        for (int f = 0; f < 8; f++) begin
            cap_gain(8'(f), 8'(f + 1), 8'(f + 90), 3'(f));
            access(1'b0, AUTO_GAIN_FILE_INDEX_REG, 16'(f), EXC_NONE);
        end
        foreach (wr_addr[i]) access(1'b1, wr_addr[i], 16'h0000, EXC_ILLEGAL_FUNC);
        access(1'b0, 16'h9D1B, 16'h0000, EXC_ILLEGAL_ADDR);
        access(1'b1, 16'h9D67, 16'h0000, EXC_ILLEGAL_ADDR);
        check_all();
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        reset_exp();
        check_all();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
